// ==== lcdfs_cfg.svh ====
`ifndef LCDFS_CFG_SVH
`define LCDFS_CFG_SVH

// Register offsets
`define LCDFS_OFF_SYS 4'h0
`define LCDFS_OFF_SWAP 4'h4
`define LCDFS_OFF_TIMING 4'h8
`define LCDFS_OFF_ROLLER 4'hC

// Layer system control fields
`define LCDFS_SYS_VID_ROLL 5
`define LCDFS_SYS_GFX_ROLL 4
`define LCDFS_SYS_VID_FMT_HI 3
`define LCDFS_SYS_VID_FMT_LO 1
`define LCDFS_SYS_GFX_FMT 0
`define LCDFS_SYS_MASK 32'h0000003F

// Swap control fields
`define LCDFS_SW_VY_HILO 17
`define LCDFS_SW_DUMMY 16
`define LCDFS_SW_DELTA 15
`define LCDFS_SW_OUT_RG 14
`define LCDFS_SW_OUT_RB 13
`define LCDFS_SW_OUT_BG 12
`define LCDFS_SW_G_ROT 11
`define LCDFS_SW_G_B8 10
`define LCDFS_SW_G_H16 9
`define LCDFS_SW_VC_B8 8
`define LCDFS_SW_VC_H16 7
`define LCDFS_SW_VY_B8 6
`define LCDFS_SW_VY_H16 5
`define LCDFS_SW_VC_ROT 4
`define LCDFS_SW_VY_ROT 3
`define LCDFS_SW_VY_MID 2
`define LCDFS_SW_V565_RB 1
`define LCDFS_SW_G565_RB 0
`define LCDFS_SWAP_MASK 32'h0003FFFF

// Panel bus timing fields
`define LCDFS_TM_OUT_SEL 31
`define LCDFS_TM_BYPASS 30
`define LCDFS_TM_REG_SEL 29
`define LCDFS_TM_FSTART 28
`define LCDFS_TM_HOLD 27
`define LCDFS_TM_HOLD_ST 26
`define LCDFS_TM_WE_END 24:20
`define LCDFS_TM_WE_ST 19:15
`define LCDFS_TM_CS_END 14:10
`define LCDFS_TM_CS_ST 9:5
`define LCDFS_TM_PERIOD 4:0
`define LCDFS_TM_MASK 32'hF9FFFFFF

`define LCDFS_RESET_VAL 32'h00000000

`endif

// ==== lcdfs_panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Panel on the parallel write bus
// ----------------------------------------
module lcdfs_panel_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Panel pins
  input wire logic panel_cs_n,
  input wire logic panel_we_n,
  input wire logic [31:0] panel_data,
  // Observations
  output logic [31:0] cap_data,
  output logic [7:0] cs_len,
  output logic [7:0] we_len,
  output logic [7:0] n_wr
);
  logic we_q;
  logic [7:0] cs_c;
  logic [7:0] we_c;
  // Latches the word on the strobe's rising edge
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      we_q <= 1'b1;
      cs_c <= 8'h0;
      we_c <= 8'h0;
      cs_len <= 8'h0;
      we_len <= 8'h0;
      n_wr <= 8'h0;
      cap_data <= 32'h0;
    end else begin
      we_q <= panel_we_n;
      if (!we_q && panel_we_n) begin
        cap_data <= panel_data;
        n_wr <= n_wr + 8'h1;
      end
      if (!panel_cs_n) cs_c <= cs_c + 8'h1;
      else if (cs_c != 8'h0) begin
        cs_len <= cs_c;
        cs_c <= 8'h0;
      end
      if (!panel_we_n) we_c <= we_c + 8'h1;
      else if (we_c != 8'h0) begin
        we_len <= we_c;
        we_c <= 8'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== lcdfs_pkg.sv ====
`default_nettype none

package lcdfs_pkg;
  typedef enum logic [2:0] {
    LCDFS_FMT_RGB888,
    LCDFS_FMT_RGB565,
    LCDFS_FMT_YCC422,
    LCDFS_FMT_YCC420_0,
    LCDFS_FMT_YCC420_1,
    LCDFS_FMT_YCC420_M,
    LCDFS_FMT_YCC444,
    LCDFS_FMT_RSVD
  } lcdfs_fmt_e;

  typedef enum logic {
    LCDFS_G_RGB888,
    LCDFS_G_RGB565
  } lcdfs_gfmt_e;
endpackage

`default_nettype wire

// ==== lcdfs_top.sv ====
// Function
// - Video roller enabled: display starts from the roller start point coordinates.
// - Graphics roller bit 4 wraps displayed area at virtual frame edges.
// - Video format bits 3:1 decode RGB888, RGB565 and YCbCr variants.
// - Graphics format bit 0 selects RGB888 when clear, RGB565 when set.
// - Bit 17 swaps highest and lowest bytes of video luma words: DBCA.
// - Bits 14, 13, 12 swap output channels to GRB, BGR, RBG.
// - Bit 11 rotates graphics words right by one byte: DABC.
// - Bit 10 swaps bytes within graphics half-words: BADC.
// - Bit 9 exchanges graphics half-words: CDAB.
// - Bits 8 and 7 give BADC and CDAB on video chroma words.
// - Bits 6 and 5 give BADC and CDAB on video luma words.
// - Bits 4 and 3 rotate video chroma and luma words right by a byte.
// - Bit 2 exchanges middle bytes of video luma words: ACBD.
// - Bits 1 and 0 swap red and blue of both RGB565 pixels.
// - Bit 15 enables delta display swap, handled by outside delta logic.
// - Bits 4:0 set the last count of the panel write period, which lasts that value plus one clock cycles.
// - Chip select asserted at bits 9:5 cycle, released at bits 14:10.
// - Write strobe asserted at bits 19:15 cycle, released at bits 24:20.
// - Bit 27 hold mode, bit 28 frame start in hold, bit 26 hold status.
// - Bit 31 selects panel path, bit 30 bypass, bit 29 register select level.
`timescale 1ns/1ps
`include "lcdfs_cfg.svh"
`default_nettype none

module lcdfs_top
  import lcdfs_pkg::*;
#(
  parameter int DW = 32,
  parameter int CW = 24
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Fetched frame data
  input wire logic fetch_valid,
  input wire logic [1:0] fetch_plane,
  input wire logic [DW-1:0] fetch_data,
  output logic swap_valid,
  output logic [1:0] swap_plane,
  output logic [DW-1:0] swap_data,
  // Decoded layer settings
  output lcdfs_fmt_e video_layer_fmt,
  output lcdfs_gfmt_e graphics_layer_fmt,
  output logic video_layer_roller_en,
  output logic graphics_layer_roller_en,
  output logic [15:0] roller_start_x,
  output logic [15:0] roller_start_y,
  output logic delta_swap_en,
  output logic dummy_swap_en,
  // Display pixel path
  input wire logic pix_valid,
  input wire logic [CW-1:0] pix_rgb,
  output logic out_valid,
  output logic [CW-1:0] out_rgb,
  // Panel data feed
  input wire logic panel_data_valid,
  input wire logic [DW-1:0] panel_data_in,
  output logic panel_data_ready,
  // Panel pins
  output logic panel_cs_n,
  output logic panel_we_n,
  output logic register_select_line,
  output logic [DW-1:0] panel_data,
  output logic panel_path_en,
  output logic panel_bypass
);

  localparam logic [1:0] PL_VY = 2'h0;
  localparam logic [1:0] PL_VC = 2'h1;
  localparam logic [1:0] PL_G = 2'h2;

  logic [31:0] sys_q;
  logic [31:0] swap_q;
  logic [31:0] tm_q;
  logic [31:0] roller_q;
  logic hold_q;
  logic busy_q;
  logic [4:0] cnt_q;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  function automatic logic [31:0] f_rot(input logic [31:0] w);
    f_rot = {w[7:0], w[31:8]};
  endfunction

  function automatic logic [31:0] f_b8(input logic [31:0] w);
    f_b8 = {w[23:16], w[31:24], w[7:0], w[15:8]};
  endfunction

  function automatic logic [31:0] f_h16(input logic [31:0] w);
    f_h16 = {w[15:0], w[31:16]};
  endfunction

  function automatic logic [31:0] f_565rb(input logic [31:0] w);
    f_565rb = {w[20:16], w[26:21], w[31:27], w[4:0], w[10:5], w[15:11]};
  endfunction

  // Write decode shared by every register
  function automatic logic f_hit(input logic wr_en, input logic [3:0] a, input logic [3:0] off);
    f_hit = wr_en && (a == off);
  endfunction

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sys_q <= `LCDFS_RESET_VAL;
    end else if (f_hit(reg_wr, reg_addr, `LCDFS_OFF_SYS)) begin
      sys_q <= reg_wdata & `LCDFS_SYS_MASK;
    end
  end

  // Reserved swap bits are dropped at the write
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      swap_q <= `LCDFS_RESET_VAL;
    end else if (f_hit(reg_wr, reg_addr, `LCDFS_OFF_SWAP)) begin
      swap_q <= reg_wdata & `LCDFS_SWAP_MASK;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      roller_q <= `LCDFS_RESET_VAL;
    end else if (f_hit(reg_wr, reg_addr, `LCDFS_OFF_ROLLER)) begin
      roller_q <= reg_wdata;
    end
  end

  // Frame start bit is self-clearing; it is consumed the next cycle
  // Hold status is never stored here; reads show the live flag
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tm_q <= `LCDFS_RESET_VAL;
    end else if (f_hit(reg_wr, reg_addr, `LCDFS_OFF_TIMING)) begin
      tm_q <= reg_wdata & `LCDFS_TM_MASK;
    end else begin
      tm_q[`LCDFS_TM_FSTART] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  // Idle cycles and unmapped offsets read as zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `LCDFS_OFF_SYS: reg_rdata <= sys_q;
        `LCDFS_OFF_SWAP: reg_rdata <= swap_q;
        `LCDFS_OFF_TIMING: begin
          reg_rdata <= tm_q;
          reg_rdata[`LCDFS_TM_HOLD_ST] <= hold_q;
        end
        `LCDFS_OFF_ROLLER: reg_rdata <= roller_q;
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // Layer settings
  // ---------------------------------------------------------------
  assign video_layer_fmt =
    lcdfs_fmt_e'(sys_q[`LCDFS_SYS_VID_FMT_HI:`LCDFS_SYS_VID_FMT_LO]);
  assign graphics_layer_fmt = lcdfs_gfmt_e'(sys_q[`LCDFS_SYS_GFX_FMT]);
  assign video_layer_roller_en = sys_q[`LCDFS_SYS_VID_ROLL];
  // Wrap at the frame edge is done by the fetch address logic
  assign graphics_layer_roller_en = sys_q[`LCDFS_SYS_GFX_ROLL];
  assign delta_swap_en = swap_q[`LCDFS_SW_DELTA];
  assign dummy_swap_en = swap_q[`LCDFS_SW_DUMMY];

  // Start point only applies while video roller is on
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      roller_start_x <= 16'h0000;
      roller_start_y <= 16'h0000;
    end else if (sys_q[`LCDFS_SYS_VID_ROLL]) begin
      roller_start_x <= roller_q[15:0];
      roller_start_y <= roller_q[31:16];
    end else begin
      roller_start_x <= 16'h0000;
      roller_start_y <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // Fetched word swapping
  // ---------------------------------------------------------------
  // Swaps run in a fixed order; each stage sees the previous result
  // The 565 swap of a layer acts only while that layer is in RGB565
  logic [31:0] sw_d;
  always_comb begin
    sw_d = fetch_data;
    case (fetch_plane)
      PL_VY: begin
        if (swap_q[`LCDFS_SW_VY_HILO]) sw_d = {sw_d[7:0], sw_d[23:8], sw_d[31:24]};
        if (swap_q[`LCDFS_SW_VY_B8]) sw_d = f_b8(sw_d);
        if (swap_q[`LCDFS_SW_VY_H16]) sw_d = f_h16(sw_d);
        if (swap_q[`LCDFS_SW_VY_ROT]) sw_d = f_rot(sw_d);
        if (swap_q[`LCDFS_SW_VY_MID]) begin
          sw_d = {sw_d[31:24], sw_d[15:8], sw_d[23:16], sw_d[7:0]};
        end
        if (swap_q[`LCDFS_SW_V565_RB] && video_layer_fmt == LCDFS_FMT_RGB565) begin
          sw_d = f_565rb(sw_d);
        end
      end
      PL_VC: begin
        if (swap_q[`LCDFS_SW_VC_B8]) sw_d = f_b8(sw_d);
        if (swap_q[`LCDFS_SW_VC_H16]) sw_d = f_h16(sw_d);
        if (swap_q[`LCDFS_SW_VC_ROT]) sw_d = f_rot(sw_d);
      end
      PL_G: begin
        if (swap_q[`LCDFS_SW_G_ROT]) sw_d = f_rot(sw_d);
        if (swap_q[`LCDFS_SW_G_B8]) sw_d = f_b8(sw_d);
        if (swap_q[`LCDFS_SW_G_H16]) sw_d = f_h16(sw_d);
        if (swap_q[`LCDFS_SW_G565_RB] && graphics_layer_fmt == LCDFS_G_RGB565) begin
          sw_d = f_565rb(sw_d);
        end
      end
      // Plane 3 passes through untouched
      default: sw_d = fetch_data;
    endcase
  end

  // Swapped word registered before format decoding downstream
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      swap_valid <= 1'b0;
      swap_plane <= 2'h0;
      swap_data <= '0;
    end else begin
      swap_valid <= fetch_valid;
      if (fetch_valid) begin
        swap_plane <= fetch_plane;
        swap_data <= sw_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output channel swapping
  // ---------------------------------------------------------------
  localparam int CH = CW / 3;
  logic [CH-1:0] r_c, g_c, b_c;
  // Channel swaps apply in turn: red-green, red-blue, blue-green
  always_comb begin
    r_c = pix_rgb[3*CH-1:2*CH];
    g_c = pix_rgb[2*CH-1:CH];
    b_c = pix_rgb[CH-1:0];
    if (swap_q[`LCDFS_SW_OUT_RG]) {r_c, g_c} = {g_c, r_c};
    if (swap_q[`LCDFS_SW_OUT_RB]) {r_c, b_c} = {b_c, r_c};
    if (swap_q[`LCDFS_SW_OUT_BG]) {g_c, b_c} = {b_c, g_c};
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      out_rgb <= '0;
    end else begin
      out_valid <= pix_valid;
      if (pix_valid) out_rgb <= {r_c, g_c, b_c};
    end
  end

  // ---------------------------------------------------------------
  // Panel bus timing
  // ---------------------------------------------------------------
  logic hold_mode;
  logic start_ok;
  logic last_cyc;
  assign hold_mode = tm_q[`LCDFS_TM_HOLD];
  assign last_cyc = (cnt_q == tm_q[`LCDFS_TM_PERIOD]);

  // In hold mode transfers wait until frame start releases the hold
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hold_q <= 1'b0;
    end else if (!hold_mode) begin
      hold_q <= 1'b0;
    end else if (tm_q[`LCDFS_TM_FSTART]) begin
      hold_q <= 1'b0;
    end else if (!hold_q && !busy_q && !panel_data_valid) begin
      hold_q <= 1'b1;
    end
  end

  // A word is taken only with the panel path selected and no hold pending
  assign start_ok = tm_q[`LCDFS_TM_OUT_SEL] && !hold_q && !busy_q;
  assign panel_data_ready = start_ok;

  // Ready stays low for the whole period, so periods never overlap
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      cnt_q <= 5'h00;
    end else if (!busy_q) begin
      if (start_ok && panel_data_valid) begin
        busy_q <= 1'b1;
        cnt_q <= 5'h00;
      end
    end else if (last_cyc) begin
      busy_q <= 1'b0;
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // Word is captured on acceptance and held through the period
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      panel_data <= '0;
    end else if (start_ok && panel_data_valid) begin
      panel_data <= panel_data_in;
    end
  end

  // ---------------------------------------------------------------
  // Panel strobes
  // ---------------------------------------------------------------
  // Both strobes drop on the last count, so they stay inside the period
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      panel_cs_n <= 1'b1;
    end else if (!busy_q) begin
      panel_cs_n <= 1'b1;
    end else if (last_cyc) begin
      panel_cs_n <= 1'b1;
    end else if (cnt_q == tm_q[`LCDFS_TM_CS_ST]) begin
      panel_cs_n <= 1'b0;
    end else if (cnt_q == tm_q[`LCDFS_TM_CS_END]) begin
      panel_cs_n <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      panel_we_n <= 1'b1;
    end else if (!busy_q) begin
      panel_we_n <= 1'b1;
    end else if (last_cyc) begin
      panel_we_n <= 1'b1;
    end else if (cnt_q == tm_q[`LCDFS_TM_WE_ST]) begin
      panel_we_n <= 1'b0;
    end else if (cnt_q == tm_q[`LCDFS_TM_WE_END]) begin
      panel_we_n <= 1'b1;
    end
  end

  assign register_select_line = tm_q[`LCDFS_TM_REG_SEL];
  assign panel_path_en = tm_q[`LCDFS_TM_OUT_SEL];
  assign panel_bypass = tm_q[`LCDFS_TM_BYPASS];

endmodule

`default_nettype wire

// ==== lcdfs_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module lcdfs_top_bench;
  logic clock, reset_n, reg_wr, reg_rd, fetch_valid, swap_valid, gfmt, vroll, groll;
  logic delta, dummy, pix_valid, out_valid, pdv, pdr, cs_n, we_n, rsel, path, byp;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, fetch_data, swap_data, pdi, pdata, cap, d;
  logic [1:0] fetch_plane, swap_plane, p;
  logic [2:0] vfmt;
  logic [15:0] rx, ry;
  logic [23:0] pix_rgb, out_rgb, c;
  logic [7:0] cs_len, we_len, n_wr;
  logic [17:0] sw;
  logic [5:0] ys;
  int n_fail = 0;
  int samples_checked = 0;
  lcdfs_top i_dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fetch_valid(fetch_valid), .fetch_plane(fetch_plane), .fetch_data(fetch_data),
    .swap_valid(swap_valid), .swap_plane(swap_plane), .swap_data(swap_data),
    .video_layer_fmt(vfmt), .graphics_layer_fmt(gfmt), .video_layer_roller_en(vroll),
    .graphics_layer_roller_en(groll), .roller_start_x(rx), .roller_start_y(ry),
    .delta_swap_en(delta), .dummy_swap_en(dummy), .pix_valid(pix_valid),
    .pix_rgb(pix_rgb), .out_valid(out_valid), .out_rgb(out_rgb), .panel_data_valid(pdv),
    .panel_data_in(pdi), .panel_data_ready(pdr), .panel_cs_n(cs_n), .panel_we_n(we_n),
    .register_select_line(rsel), .panel_data(pdata), .panel_path_en(path),
    .panel_bypass(byp));
  lcdfs_panel_model i_panel (.clock(clock), .reset_n(reset_n), .panel_cs_n(cs_n),
    .panel_we_n(we_n), .panel_data(pdata), .cap_data(cap), .cs_len(cs_len),
    .we_len(we_len), .n_wr(n_wr));
  function automatic logic [31:0] b8(input logic [31:0] x);
    return {x[23:16], x[31:24], x[7:0], x[15:8]};
  endfunction
  function automatic logic [31:0] h16(input logic [31:0] x);
    return {x[15:0], x[31:16]};
  endfunction
  function automatic logic [31:0] rot(input logic [31:0] x);
    return {x[7:0], x[31:8]};
  endfunction
  function automatic logic [31:0] rb(input logic [31:0] x);
    return {x[20:16], x[26:21], x[31:27], x[4:0], x[10:5], x[15:11]};
  endfunction
  // Expected fetched word after the plane's swaps
  function automatic logic [31:0] xs(input logic [1:0] pl, input logic [17:0] s,
      input logic [5:0] y, input logic [31:0] x);
    logic [31:0] r;
    r = x;
    if (pl == 2'h0) begin
      if (s[17]) r = {r[7:0], r[23:8], r[31:24]};
      if (s[6]) r = b8(r);
      if (s[5]) r = h16(r);
      if (s[3]) r = rot(r);
      if (s[2]) r = {r[31:24], r[15:8], r[23:16], r[7:0]};
      if (s[1] && y[3:1] == 3'h1) r = rb(r);
    end else if (pl == 2'h1) begin
      if (s[8]) r = b8(r);
      if (s[7]) r = h16(r);
      if (s[4]) r = rot(r);
    end else if (pl == 2'h2) begin
      if (s[11]) r = rot(r);
      if (s[10]) r = b8(r);
      if (s[9]) r = h16(r);
      if (s[0] && y[0]) r = rb(r);
    end
    return r;
  endfunction
  function automatic logic [23:0] px(input logic [17:0] s, input logic [23:0] x);
    logic [23:0] r;
    r = x;
    if (s[14]) r = {r[15:8], r[23:16], r[7:0]};
    if (s[13]) r = {r[7:0], r[15:8], r[23:16]};
    if (s[12]) r = {r[23:16], r[7:0], r[15:8]};
    return r;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
    @(posedge clock);
  endtask
  task automatic pw(input logic [31:0] v);
    int k;
    logic [7:0] n;
    n = n_wr;
    k = 0;
    pdv <= 1'b1;
    pdi <= v;
    do begin @(negedge clock); k++; end while (!pdr && k < 40);
    @(posedge clock);
    pdv <= 1'b0;
    while (n_wr == n && k < 80) begin @(posedge clock); k++; end
    `CHK(cap, v)
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #2000000;
    n_fail++;
    wrap_up();
  end
  initial begin
    {reset_n, reg_wr, reg_rd, fetch_valid, pix_valid, pdv} = 6'h0;
    {reg_addr, reg_wdata, fetch_plane, fetch_data, pix_rgb, pdi} = '0;
    void'($urandom(32'h8fc07bc4));
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(4'h4, 32'h0);
    wr(4'h4, 32'hFFFFFFFF);
    rd(4'h4, 32'h0003FFFF);
    wr(4'h8, 32'hE1FFFFFF);
    rd(4'h8, 32'hE1FFFFFF);
    `CHK({path, byp, rsel, delta, dummy}, 5'h1F)
    wr(4'h0, 32'hFFFFFFFF);
    rd(4'h0, 32'h0000003F);
    wr(4'hC, 32'h12345678);
    rd(4'h2, 32'h0);
    `CHK({vroll, groll, ry, rx}, {2'h3, 32'h12345678})
    for (int f = 0; f < 16; f++) begin
      wr(4'h0, f);
      #1 `CHK({vfmt, gfmt}, f[3:0])
      `CHK({ry, rx}, 32'h0)
      @(posedge clock);
    end
    $display("test registers done");
    for (int i = 0; i < 80; i++) begin
      sw = (i < 4) ? 18'h3FFFF : 18'($urandom);
      ys = (i < 8) ? {2'h0, 3'h1, i[0]} : 6'($urandom);
      p = (i < 4) ? i[1:0] : 2'($urandom);
      d = $urandom;
      c = 24'($urandom);
      wr(4'h4, {14'h0, sw});
      wr(4'h0, {26'h0, ys});
      fetch_valid <= 1'b1;
      pix_valid <= 1'b1;
      fetch_plane <= p;
      fetch_data <= d;
      pix_rgb <= c;
      @(posedge clock);
      fetch_valid <= 1'b0;
      pix_valid <= 1'b0;
      #1 `CHK(swap_data, xs(p, sw, ys, d))
      `CHK(out_rgb, px(sw, c))
      @(posedge clock);
    end
    $display("test swaps done");
    wr(4'h8, 32'h08000000);
    repeat (3) @(posedge clock);
    rd(4'h8, 32'h0C000000);
    wr(4'h8, 32'h18000000);
    rd(4'h8, 32'h08000000);
    wr(4'h8, 32'h0);
    @(posedge clock);
    rd(4'h8, 32'h0);
    $display("test hold done");
    wr(4'h8, 32'hA0411426);
    for (int k = 0; k < 3; k++) pw($urandom);
    repeat (6) @(posedge clock);
    `CHK({rsel, cs_len, we_len, n_wr}, {1'b1, 8'h04, 8'h02, 8'h03})
    $display("test panel done");
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== lcdfs_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module lcdfs_top_sva #(
  parameter int DW = 32,
  parameter int CW = 24
) (
  // Watched ports
  input wire logic clock,
  input wire logic reset_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic fetch_valid,
  input wire logic [1:0] fetch_plane,
  input wire logic [DW-1:0] fetch_data,
  input wire logic swap_valid,
  input wire logic [1:0] swap_plane,
  input wire logic [DW-1:0] swap_data,
  input wire logic pix_valid,
  input wire logic out_valid,
  input wire logic panel_data_valid,
  input wire logic [DW-1:0] panel_data_in,
  input wire logic panel_data_ready,
  input wire logic [DW-1:0] panel_data,
  input wire logic panel_path_en
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  property p_swap_lat; fetch_valid |=> swap_valid; endproperty
  property p_swap_idle; !fetch_valid ##1 1'b1 |-> !swap_valid; endproperty
  property p_plane; fetch_valid |=> swap_plane == $past(fetch_plane); endproperty
  property p_pass; fetch_valid && fetch_plane == 2'h3 |=> swap_data == $past(fetch_data);
  endproperty
  property p_pix; pix_valid |=> out_valid; endproperty
  property p_take; panel_data_valid && panel_data_ready
    |=> !panel_data_ready && panel_data == $past(panel_data_in); endproperty
  property p_path; panel_data_ready |-> panel_path_en; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
  a_swap_lat: assert property (p_swap_lat) else $error("swap valid late");
  a_swap_idle: assert property (p_swap_idle) else $error("swap valid spurious");
  a_plane: assert property (p_plane) else $error("plane tag wrong");
  a_pass: assert property (p_pass) else $error("passthrough altered");
  a_pix: assert property (p_pix) else $error("pixel valid late");
  a_take: assert property (p_take) else $error("panel word not taken");
  a_path: assert property (p_path) else $error("ready without path");
  c_fetch: cover property (fetch_valid ##1 swap_valid);
  c_pix: cover property (pix_valid ##1 out_valid);
  c_take: cover property (panel_data_valid && panel_data_ready);
endmodule
bind lcdfs_top lcdfs_top_sva #(.DW(DW), .CW(CW)) i_sva (.clock(clock), .reset_n(reset_n),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_valid(fetch_valid),
  .fetch_plane(fetch_plane), .fetch_data(fetch_data), .swap_valid(swap_valid),
  .swap_plane(swap_plane), .swap_data(swap_data), .pix_valid(pix_valid),
  .out_valid(out_valid), .panel_data_valid(panel_data_valid),
  .panel_data_in(panel_data_in), .panel_data_ready(panel_data_ready),
  .panel_data(panel_data), .panel_path_en(panel_path_en));
`default_nettype wire
